// ===== hw/mttc_pkg.sv
package mttc_pkg;
    localparam int unsigned MTTC_WGT_W = 24;
    localparam int unsigned MTTC_CNT_W = 16;
    localparam int unsigned MTTC_ACC_W = 40;
    localparam int unsigned MTTC_CLK_HZ = 200000000;
    localparam int unsigned MTTC_CMP_PER_S = 50;
    localparam int unsigned MTTC_CMP_CYCLES = MTTC_CLK_HZ / MTTC_CMP_PER_S;
    localparam int unsigned MTTC_PCT_SCALE = 100;
    localparam logic [2:0] MTTC_PRIV_SUPER = 3'h2;

    typedef enum logic [1:0] {
        MTTC_ST_READY,
        MTTC_ST_RUNNING,
        MTTC_ST_PAUSED
    } mttc_state_t;
endpackage

// ===== hw/mttc_rate_div.sv
`timescale 1ns/1ps
module mttc_rate_div #(
    parameter int unsigned DIV = mttc_pkg::MTTC_CMP_CYCLES
) (
    input wire logic clk_sys,
    input wire logic rstn,
    output logic tick
);
    localparam int unsigned CW = $clog2(DIV);
    logic [CW-1:0] cnt_q;
    logic tick_q;

    initial begin
        if (DIV < 2) begin
            $error("mttc_rate_div: DIV must be at least 2");
        end
    end

    assign tick = tick_q;

    always_ff @(posedge clk_sys) begin
        if (!rstn) begin
            cnt_q <= '0;
            tick_q <= 1'b0;
        end else if (cnt_q == CW'(DIV - 1)) begin
            cnt_q <= '0;
            tick_q <= 1'b1;
        end else begin
            cnt_q <= cnt_q + 1'b1;
            tick_q <= 1'b0;
        end
    end
endmodule // mttc_rate_div

// ===== hw/mttc_sync.sv
`timescale 1ns/1ps
module mttc_sync (
    input wire logic clk_sys,
    input wire logic rstn,
    input wire logic din,
    output logic rise
);
    logic s1_q;
    logic s2_q;
    logic s3_q;
    logic lvl_q;

    // Level moves only once the second and third stages agree
    assign rise = (s2_q == s3_q) && s3_q && !lvl_q;

    always_ff @(posedge clk_sys) begin
        if (!rstn) begin
            s1_q <= 1'b0;
            s2_q <= 1'b0;
            s3_q <= 1'b0;
            lvl_q <= 1'b0;
        end else begin
            s1_q <= din;
            s2_q <= s1_q;
            s3_q <= s2_q;
            if (s2_q == s3_q) begin
                lvl_q <= s3_q;
            end
        end
    end
endmodule // mttc_sync

// ===== hw/mttc_ctrl.sv
`timescale 1ns/1ps
module mttc_ctrl #(
    parameter int unsigned WGT_W = mttc_pkg::MTTC_WGT_W,
    parameter int unsigned CNT_W = mttc_pkg::MTTC_CNT_W,
    parameter int unsigned ACC_W = mttc_pkg::MTTC_ACC_W,
    parameter int unsigned CMP_CYCLES = mttc_pkg::MTTC_CMP_CYCLES
) (
    input wire logic clk_sys,
    input wire logic rstn,
    input wire logic [WGT_W-1:0] gross_wgt,
    input wire logic [WGT_W-1:0] net_wgt,
    input wire logic src_net,
    input wire logic weigh_out,
    input wire logic latched_mode,
    input wire logic two_speed,
    input wire logic concurrent,
    input wire logic tol_pct,
    input wire logic [WGT_W-1:0] target,
    input wire logic [WGT_W-1:0] spill,
    input wire logic [WGT_W-1:0] fine_feed,
    input wire logic [WGT_W-1:0] tol_plus,
    input wire logic [WGT_W-1:0] tol_minus,
    input wire logic key_start,
    input wire logic key_pause,
    input wire logic key_abort,
    input wire logic key_resume,
    input wire logic din_start_resume,
    input wire logic din_pause_abort,
    input wire logic [2:0] priv_level,
    input wire logic tot_clear_sub,
    input wire logic tot_clear_all,
    input wire logic tot_print,
    input wire logic clr_sub_after_print,
    input wire logic clr_all_after_print,
    output logic feed_out,
    output logic fast_feed_out,
    output mttc_pkg::mttc_state_t run_state,
    output logic cmp_done,
    output logic in_tol,
    output logic print_req,
    output logic cmd_denied,
    output logic [CNT_W-1:0] sub_count,
    output logic [ACC_W-1:0] sub_weight,
    output logic [CNT_W-1:0] grand_count,
    output logic [ACC_W-1:0] grand_weight
);
    import mttc_pkg::*;

    initial begin
        if (WGT_W < 8 || ACC_W < WGT_W || CNT_W < 2 || CMP_CYCLES < 2) begin
            $error("mttc_ctrl: unsupported widths or comparison period");
        end
    end

    // Saturating subtract keeps thresholds from wrapping below zero
    function automatic logic [WGT_W-1:0] sat_sub(input logic [WGT_W-1:0] a,
                                                 input logic [WGT_W-1:0] b);
        sat_sub = (a > b) ? a - b : '0;
    endfunction

    function automatic logic [WGT_W-1:0] pct_of(input logic [WGT_W-1:0] base,
                                                input logic [WGT_W-1:0] pct);
        logic [2*WGT_W-1:0] prod;
        prod = base * pct;
        pct_of = WGT_W'(prod / (2*WGT_W)'(MTTC_PCT_SCALE));
    endfunction

    logic tick;
    logic din_sr_rise;
    logic din_pa_rise;

    mttc_rate_div #(
        .DIV(CMP_CYCLES)
    ) u_div (
        .clk_sys(clk_sys),
        .rstn(rstn),
        .tick(tick)
    );

    mttc_sync u_sync_sr (
        .clk_sys(clk_sys),
        .rstn(rstn),
        .din(din_start_resume),
        .rise(din_sr_rise)
    );

    mttc_sync u_sync_pa (
        .clk_sys(clk_sys),
        .rstn(rstn),
        .din(din_pause_abort),
        .rise(din_pa_rise)
    );

    mttc_state_t state_q;
    mttc_state_t state_d;
    logic [WGT_W-1:0] src_q;
    logic [WGT_W-1:0] ref_q;
    logic [WGT_W-1:0] tgt_q;
    logic [WGT_W-1:0] spill_q;
    logic [WGT_W-1:0] fine_q;
    logic [WGT_W-1:0] tolp_q;
    logic [WGT_W-1:0] tolm_q;
    logic wout_q;
    logic coarse_done_q;
    logic feed_q;
    logic fast_q;
    logic done_q;
    logic intol_q;
    logic print_q;
    logic denied_q;
    logic [CNT_W-1:0] sub_cnt_q;
    logic [ACC_W-1:0] sub_wgt_q;
    logic [CNT_W-1:0] gr_cnt_q;
    logic [ACC_W-1:0] gr_wgt_q;

    // Commands: control is honoured only in latched mode
    wire cmd_start = latched_mode && (key_start || din_sr_rise);
    wire cmd_pause = latched_mode && (key_pause || din_pa_rise);
    wire cmd_abort = latched_mode && (key_abort || din_pa_rise);
    wire cmd_resume = latched_mode && (key_resume || din_sr_rise);
    // Start captures target values once, so resume reuses them
    wire load_tgt = (state_q == MTTC_ST_READY) && cmd_start;
    wire coin_on = !latched_mode;

    // Weight source and fed amount
    wire [WGT_W-1:0] src_now = src_net ? net_wgt : gross_wgt;
    // At start, judge the fresh weight and new targets, not what the last tick left behind
    wire [WGT_W-1:0] smp_w = load_tgt ? src_now : src_q;
    wire [WGT_W-1:0] ref_w = load_tgt ? src_now : ref_q;
    wire [WGT_W-1:0] tgt_w = load_tgt ? target : tgt_q;
    wire [WGT_W-1:0] spill_w = load_tgt ? spill : spill_q;
    wire [WGT_W-1:0] fine_w = load_tgt ? fine_feed : fine_q;
    wire wout_w = load_tgt ? weigh_out : wout_q;
    // Weigh-in measures the weight itself; weigh-out measures what has left since start
    wire [WGT_W-1:0] fed_amt = wout_w ? sat_sub(ref_w, smp_w) : smp_w;
    wire [WGT_W-1:0] coin_amt = weigh_out ? sat_sub(ref_q, src_q) : src_q;

    wire [WGT_W-1:0] final_pt = sat_sub(tgt_w, spill_w);
    wire [WGT_W-1:0] coarse_pt = sat_sub(final_pt, fine_w);
    wire reached_final = fed_amt >= final_pt;
    wire reached_coarse = fed_amt >= coarse_pt;

    wire [WGT_W-1:0] tolp_w = tol_pct ? pct_of(tgt_q, tolp_q) : tolp_q;
    wire [WGT_W-1:0] tolm_w = tol_pct ? pct_of(tgt_q, tolm_q) : tolm_q;
    wire [WGT_W:0] hi_lim = {1'b0, tgt_q} + {1'b0, tolp_w};
    wire in_tol_now = (fed_amt >= sat_sub(tgt_q, tolm_w)) && ({1'b0, fed_amt} <= hi_lim);

    wire running = (state_q == MTTC_ST_RUNNING);
    // A pause in the finishing cycle wins, so no transaction is counted for it
    wire run_finish = running && tick && reached_final && !cmd_pause;

    always_comb begin
        state_d = state_q;
        unique case (state_q)
            MTTC_ST_READY: begin
                if (cmd_start) begin
                    state_d = MTTC_ST_RUNNING;
                end
            end
            MTTC_ST_RUNNING: begin
                if (cmd_pause) begin
                    state_d = MTTC_ST_PAUSED;
                end else if (run_finish) begin
                    state_d = MTTC_ST_READY;
                end
            end
            MTTC_ST_PAUSED: begin
                if (cmd_resume) begin
                    state_d = MTTC_ST_RUNNING;
                end else if (cmd_abort) begin
                    state_d = MTTC_ST_READY;
                end
            end
        endcase
        if (!latched_mode) begin
            state_d = MTTC_ST_READY;
        end
    end

    // Feed decisions, evaluated on each comparison tick
    logic feed_d;
    logic fast_d;
    logic coarse_done_d;
    always_comb begin
        feed_d = feed_q;
        fast_d = fast_q;
        coarse_done_d = coarse_done_q;
        if (coin_on) begin
            coarse_done_d = 1'b0;
            fast_d = 1'b0;
            if (tick) begin
                feed_d = coin_amt < final_pt;
            end
        end else if (state_d != MTTC_ST_RUNNING) begin
            // Paused or finished: latch holds every feed off
            feed_d = 1'b0;
            fast_d = 1'b0;
            if (state_q != MTTC_ST_PAUSED || state_d != MTTC_ST_PAUSED) begin
                coarse_done_d = (state_d == MTTC_ST_PAUSED) && coarse_done_q;
            end
        end else if (tick || state_q != MTTC_ST_RUNNING) begin
            if (!two_speed) begin
                feed_d = !reached_final;
                fast_d = 1'b0;
            end else begin
                coarse_done_d = coarse_done_q || reached_coarse;
                fast_d = !coarse_done_d;
                if (concurrent) begin
                    feed_d = !reached_final;
                end else begin
                    feed_d = coarse_done_d && !reached_final;
                end
            end
        end
        // A speed change mid-run must not leave the coarse valve open until the next tick
        if (!two_speed) begin
            fast_d = 1'b0;
        end
    end

    // Totals are privileged operations
    wire priv_ok = priv_level >= MTTC_PRIV_SUPER;
    wire any_tot_cmd = tot_clear_sub || tot_clear_all || tot_print;
    wire do_print = tot_print && priv_ok;
    wire clr_all = priv_ok && (tot_clear_all || (tot_print && clr_all_after_print));
    wire clr_sub = clr_all || (priv_ok && (tot_clear_sub ||
                   (tot_print && clr_sub_after_print)));
    wire [ACC_W-1:0] fed_ext = ACC_W'(fed_amt);

    always_ff @(posedge clk_sys) begin
        if (!rstn) begin
            state_q <= MTTC_ST_READY;
            coarse_done_q <= 1'b0;
            feed_q <= 1'b0;
            fast_q <= 1'b0;
        end else begin
            state_q <= state_d;
            coarse_done_q <= coarse_done_d;
            feed_q <= feed_d;
            fast_q <= fast_d;
        end
    end

    always_ff @(posedge clk_sys) begin
        if (!rstn) begin
            src_q <= '0;
        end else if (tick || load_tgt) begin
            src_q <= src_now;
        end
    end

    always_ff @(posedge clk_sys) begin
        if (!rstn) begin
            ref_q <= '0;
            tgt_q <= '0;
            spill_q <= '0;
            fine_q <= '0;
            tolp_q <= '0;
            tolm_q <= '0;
            wout_q <= 1'b0;
        end else if (load_tgt || coin_on) begin
            ref_q <= (load_tgt || !weigh_out) ? src_now : ref_q;
            tgt_q <= target;
            spill_q <= spill;
            fine_q <= fine_feed;
            tolp_q <= tol_plus;
            tolm_q <= tol_minus;
            wout_q <= weigh_out;
        end
    end

    always_ff @(posedge clk_sys) begin
        if (!rstn) begin
            done_q <= 1'b0;
            intol_q <= 1'b0;
        end else begin
            done_q <= run_finish;
            if (tick) begin
                intol_q <= in_tol_now;
            end
        end
    end

    // A completed run counts as one transaction; clear wins within the same cycle
    always_ff @(posedge clk_sys) begin
        if (!rstn) begin
            sub_cnt_q <= '0;
            sub_wgt_q <= '0;
            gr_cnt_q <= '0;
            gr_wgt_q <= '0;
            print_q <= 1'b0;
            denied_q <= 1'b0;
        end else begin
            print_q <= do_print;
            denied_q <= any_tot_cmd && !priv_ok;
            if (clr_sub) begin
                sub_cnt_q <= '0;
                sub_wgt_q <= '0;
            end else if (run_finish) begin
                sub_cnt_q <= sub_cnt_q + 1'b1;
                sub_wgt_q <= sub_wgt_q + fed_ext;
            end
            if (clr_all) begin
                gr_cnt_q <= '0;
                gr_wgt_q <= '0;
            end else if (run_finish) begin
                gr_cnt_q <= gr_cnt_q + 1'b1;
                gr_wgt_q <= gr_wgt_q + fed_ext;
            end
        end
    end

    assign feed_out = feed_q;
    assign fast_feed_out = fast_q;
    assign run_state = state_q;
    assign cmp_done = done_q;
    assign in_tol = intol_q;
    assign print_req = print_q;
    assign cmd_denied = denied_q;
    assign sub_count = sub_cnt_q;
    assign sub_weight = sub_wgt_q;
    assign grand_count = gr_cnt_q;
    assign grand_weight = gr_wgt_q;
endmodule // mttc_ctrl

// ===== sim/mttc_ctrl_checker.sv
`timescale 1ns/1ps
module mttc_ctrl_checker #(
    parameter int unsigned CNT_W = 16
) (
    input wire logic clk_sys,
    input wire logic rstn,
    input wire logic latched_mode,
    input wire logic two_speed,
    input wire logic concurrent,
    input wire logic key_start,
    input wire logic key_pause,
    input wire logic [2:0] priv_level,
    input wire logic tot_clear_sub,
    input wire logic tot_print,
    input wire logic clr_sub_after_print,
    input wire logic feed_out,
    input wire logic fast_feed_out,
    input wire mttc_pkg::mttc_state_t run_state,
    input wire logic cmp_done,
    input wire logic print_req,
    input wire logic cmd_denied,
    input wire logic [CNT_W-1:0] sub_count
);
    import mttc_pkg::*;
    default clocking @(posedge clk_sys);
    endclocking
    default disable iff (!rstn);
    sequence ready_s;
        latched_mode && run_state == MTTC_ST_READY;
    endsequence
    sequence running_s;
        latched_mode && run_state == MTTC_ST_RUNNING;
    endsequence
    pause_drop_a: assert property (running_s ##0 key_pause |=>
        !feed_out && !fast_feed_out && run_state == MTTC_ST_PAUSED) else $error("pause ignored");
    start_run_a: assert property (ready_s ##0 key_start |=>
        run_state == MTTC_ST_RUNNING) else $error("start ignored");
    unlatched_idle_a: assert property (!latched_mode [*2] ##0 run_state == MTTC_ST_READY
        |=> run_state == MTTC_ST_READY) else $error("control acted unlatched");
    single_speed_a: assert property (!two_speed [*2] |-> !fast_feed_out)
        else $error("coarse used in single speed");
    one_speed_a: assert property ((two_speed && !concurrent) [*2]
        |-> !(feed_out && fast_feed_out)) else $error("two speeds at once");
    done_idle_a: assert property (cmp_done |-> run_state == MTTC_ST_READY && !feed_out
        && !fast_feed_out && $past(run_state) == MTTC_ST_RUNNING) else $error("run end wrong");
    denied_a: assert property (tot_clear_sub && priv_level < MTTC_PRIV_SUPER |=>
        cmd_denied && $stable(sub_count)) else $error("clear not refused");
    print_clear_a: assert property (tot_print && clr_sub_after_print
        && priv_level >= MTTC_PRIV_SUPER |=> print_req && sub_count == '0)
        else $error("print clear wrong");
endmodule // mttc_ctrl_checker

// ===== sim/mttc_feeder.sv
`timescale 1ns/1ps
module mttc_feeder #(
    parameter int unsigned WGT_W = 24,
    parameter int unsigned FULL = 256
) (
    input wire logic clk_sys,
    input wire logic empty,
    input wire logic remove,
    input wire logic feed_out,
    input wire logic fast_feed_out,
    output logic [WGT_W-1:0] wgt
);
    // Coarse valve flows twice the slow one; no spill, so overshoot comes from tick lag only
    always_ff @(posedge clk_sys) begin
        // Weigh-out starts from a loaded scale, so emptying then loads the start weight
        if (empty) begin
            wgt <= remove ? WGT_W'(FULL) : '0;
        end else if (remove) begin
            wgt <= wgt - WGT_W'(feed_out) - WGT_W'({fast_feed_out, 1'b0});
        end else begin
            wgt <= wgt + WGT_W'(feed_out) + WGT_W'({fast_feed_out, 1'b0});
        end
    end
endmodule // mttc_feeder

// ===== sim/mttc_ctrl_tb.sv
`timescale 1ns/1ps
module mttc_ctrl_tb;
    import mttc_pkg::*;
    localparam int CMPC = 20;
    logic clk_sys, rstn, src_net, latched_mode, two_speed, concurrent, empty;
    logic [6:0] pl;
    logic [1:0] din;
    logic clr_sub_after_print, clr_all_after_print, feed_out, fast_feed_out;
    logic cmp_done, in_tol, print_req, cmd_denied;
    logic weigh_out = 1'b0;
    logic remove = 1'b0;
    logic [MTTC_WGT_W-1:0] net_wgt;
    logic tol_pct = 1'b0;
    logic [2:0] priv_level;
    logic [MTTC_WGT_W-1:0] gross_wgt, target, spill, fine_feed;
    logic [MTTC_WGT_W-1:0] tol_plus = 24'h0a;
    logic [MTTC_WGT_W-1:0] tol_minus = 24'h0a;
    logic [15:0] sub_count, grand_count;
    logic [39:0] sub_weight, grand_weight;
    mttc_state_t run_state;
    int n_errors = 0;
    int comparisons = 0;
    // Net differs from gross, so the chosen source shows in the cut-off point
    assign net_wgt = gross_wgt >> 1;
    mttc_ctrl #(.CMP_CYCLES(CMPC)) dut (.*, .net_wgt(net_wgt), .key_start(pl[0]),
        .key_pause(pl[1]), .key_abort(pl[2]), .key_resume(pl[3]), .tot_clear_sub(pl[4]),
        .tot_clear_all(pl[5]), .tot_print(pl[6]), .din_start_resume(din[0]),
        .din_pause_abort(din[1]));
    mttc_feeder feeder (.clk_sys(clk_sys), .empty(empty), .remove(remove), .feed_out(feed_out),
        .fast_feed_out(fast_feed_out), .wgt(gross_wgt));
    initial begin
        clk_sys = 1'b0;
        forever #2.5 clk_sys = ~clk_sys;
    end
    task automatic chk(input logic [39:0] got, input logic [39:0] exp);
        comparisons++;
        if (got !== exp) begin
            n_errors++;
            $display("mismatch at %0t: got %0h expected %0h", $time, got, exp);
        end
    endtask
    task automatic wrap_up();
        $display("%0d comparisons, %0d mismatches", comparisons, n_errors);
        if (n_errors == 0 && comparisons > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask
    task automatic cyc(input int n);
        repeat (n) @(posedge clk_sys);
        #1;
    endtask
    // Bits of pl: start, pause, abort, resume, clear sub, clear all, print
    task automatic pulse(input int k);
        @(posedge clk_sys);
        pl[k] <= 1'b1;
        @(posedge clk_sys);
        pl <= '0;
        #1;
    endtask
    // Pins pass a synchroniser, so allow well beyond its latency
    task automatic pin(input int k);
        repeat (3) @(posedge clk_sys);
        din[k] <= 1'b1;
        repeat (8) @(posedge clk_sys);
        din <= '0;
        #1;
    endtask
    task automatic wait_on(input int k);
        for (int i = 0; i < 3000; i++) begin
            cyc(1);
            if (k == 0 ? cmp_done === 1'b1 : fast_feed_out === 1'b0) return;
        end
        n_errors++;
        $display("mismatch at %0t: wait ran out", $time);
        wrap_up();
    endtask
    task automatic t_coinc();
        cyc(3 * CMPC);
        chk(feed_out, 1'b1);
        @(posedge clk_sys);
        empty <= 1'b0;
        cyc(260);
        chk(feed_out, 1'b0);
        chk(gross_wgt >= 24'ha0, 1'b1);
        pulse(0);
        chk(run_state, MTTC_ST_READY);
        $display("test coincidence done");
    endtask
    task automatic t_single();
        logic [15:0] s;
        logic [39:0] sw;
        s = sub_count;
        sw = sub_weight;
        @(posedge clk_sys);
        {latched_mode, src_net, empty} <= 3'b101;
        cyc(3 * CMPC);
        chk(feed_out, 1'b0);
        empty <= 1'b0;
        pulse(0);
        chk(run_state, MTTC_ST_RUNNING);
        chk(feed_out, 1'b1);
        chk(fast_feed_out, 1'b0);
        wait_on(0);
        chk(gross_wgt >= 24'h50, 1'b1);
        chk(sub_count, s + 16'h1);
        chk(sub_weight - sw >= 40'h50, 1'b1);
        @(posedge clk_sys);
        empty <= 1'b1;
        cyc(3 * CMPC);
        chk(feed_out, 1'b0);
        $display("test single speed done");
    endtask
    task automatic t_two();
        @(posedge clk_sys);
        {two_speed, concurrent, empty} <= 3'b110;
        target <= 24'h3e8;
        spill <= 24'h64;
        fine_feed <= 24'h190;
        pulse(0);
        chk({feed_out, fast_feed_out}, 2'b11);
        wait_on(1);
        chk(feed_out, 1'b1);
        chk(gross_wgt >= 24'h1f4 && gross_wgt < 24'h2bc, 1'b1);
        wait_on(0);
        @(posedge clk_sys);
        {concurrent, empty} <= 2'b01;
        @(posedge clk_sys);
        empty <= 1'b0;
        pulse(0);
        chk({feed_out, fast_feed_out}, 2'b01);
        wait_on(1);
        cyc(1);
        chk(feed_out, 1'b1);
        wait_on(0);
        $display("test two speed done");
    endtask
    task automatic t_totals();
        logic [15:0] s, g;
        s = sub_count;
        g = grand_count;
        @(posedge clk_sys);
        priv_level <= 3'h1;
        clr_all_after_print <= 1'b1;
        pulse(4);
        chk(cmd_denied, 1'b1);
        pulse(6);
        chk({print_req, sub_count, grand_count}, {1'b0, s, g});
        @(posedge clk_sys);
        priv_level <= 3'h2;
        {clr_all_after_print, clr_sub_after_print} <= 2'b01;
        pulse(6);
        chk({print_req, sub_count, grand_count}, {1'b1, 16'h0, g});
        chk(sub_weight, 40'h0);
        pulse(5);
        chk({grand_count, grand_weight}, 56'h0);
        $display("test totals done");
    endtask
    task automatic t_pause();
        logic [MTTC_WGT_W-1:0] w;
        @(posedge clk_sys);
        {two_speed, empty} <= 2'b01;
        @(posedge clk_sys);
        empty <= 1'b0;
        pin(0);
        chk(run_state, MTTC_ST_RUNNING);
        pulse(2);
        chk(run_state, MTTC_ST_RUNNING);
        pulse(1);
        chk({run_state, feed_out}, {MTTC_ST_PAUSED, 1'b0});
        w = gross_wgt;
        target <= 24'h0;
        pulse(3);
        cyc(3 * CMPC);
        chk({run_state, feed_out}, {MTTC_ST_RUNNING, 1'b1});
        chk(gross_wgt > w, 1'b1);
        pin(1);
        chk(run_state, MTTC_ST_PAUSED);
        pulse(2);
        chk({run_state, feed_out}, {MTTC_ST_READY, 1'b0});
        $display("test pause done");
    endtask
    task automatic t_out();
        @(posedge clk_sys);
        {weigh_out, remove, empty} <= 3'b111;
        target <= 24'h40;
        spill <= 24'h10;
        @(posedge clk_sys);
        empty <= 1'b0;
        pulse(0);
        chk(feed_out, 1'b1);
        wait_on(0);
        chk(gross_wgt <= 24'hd0, 1'b1);
        $display("test weigh-out done");
    endtask
    // Scale held empty in coincidence mode, so the fed amount stays zero
    task automatic t_tol();
        @(posedge clk_sys);
        {latched_mode, weigh_out, remove, empty, tol_pct} <= 5'b00011;
        target <= 24'h0a;
        tol_minus <= 24'h32;
        cyc(3 * CMPC);
        chk(in_tol, 1'b0);
        @(posedge clk_sys);
        tol_pct <= 1'b0;
        cyc(3 * CMPC);
        chk(in_tol, 1'b1);
        $display("test tolerance done");
    endtask
    initial begin
        {pl, din, src_net, latched_mode, two_speed, concurrent} = '0;
        {clr_sub_after_print, clr_all_after_print, rstn} = '0;
        empty = 1'b1;
        priv_level = 3'h0;
        target = 24'h64;
        spill = 24'h14;
        fine_feed = 24'h0;
        src_net = 1'b1;
        repeat (4) @(posedge clk_sys);
        rstn <= 1'b1;
        cyc(1);
        chk({run_state, feed_out, sub_count, grand_count}, 35'h0);
        t_coinc();
        t_single();
        t_two();
        t_totals();
        t_pause();
        t_out();
        t_tol();
        wrap_up();
    end
endmodule // mttc_ctrl_tb
bind mttc_ctrl mttc_ctrl_checker #(.CNT_W(CNT_W)) chk_u (.*);
